// ==== ilsc_scan.sv ====
// Scan step engine for latch, pulse and interlock instructions.
// Assumes the program feeds one step per request and an APB master.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ilsc_scan #(
    parameter int AW          = ilsc_pkg::ADDR_W,
    parameter int RETAIN_BASE = ilsc_pkg::RETAIN_BASE
) (
    input  wire logic          CLK_SYS,
    input  wire logic          RESET,
    input  wire logic          PSEL,
    input  wire logic          PENABLE,
    input  wire logic          PWRITE,
    input  wire logic [11:0]   PADDR,
    input  wire logic [31:0]   PWDATA,
    output logic [31:0]        PRDATA,
    output logic               PREADY,
    output logic               PSLVERR,
    input  wire logic          STEP_VALID,
    output logic               STEP_READY,
    input  wire logic [3:0]    STEP_OP,
    input  wire logic [AW-1:0] STEP_ADDR,
    input  wire logic          STEP_COND,
    input  wire logic          STEP_SET,
    input  wire logic          STEP_RESET,
    output logic               RESULT_VALID,
    output logic [AW-1:0]      RESULT_ADDR,
    output logic               RESULT_WRITE,
    output logic               RESULT_BIT,
    output logic               TIMER_RESET,
    output logic               COUNTER_HOLD,
    output logic               EXEC_ENABLE,
    output logic               ILOCK_WARN
);
    localparam logic [AW-1:0] CLR_LAST = AW'(RETAIN_BASE - 1);

    ////////////////////////////////////////////////////////////////////////
    // State
    ilsc_pkg::ilsc_state_t state_reg, state_next;
    logic [AW-1:0] clr_addr_reg, clr_addr_next;
    logic [3:0]    op_reg, op_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic          cond_reg, cond_next;
    logic          set_reg, set_next;
    logic          rst_in_reg, rst_in_next;
    logic          rv_reg, rv_next;
    logic [AW-1:0] ra_reg, ra_next;
    logic          rw_reg, rw_next;
    logic          rb_reg, rb_next;
    logic          tr_reg, tr_next;
    logic          ch_reg, ch_next;
    logic          ee_reg, ee_next;
    logic [31:0]   ctrl_reg, ctrl_next;
    logic          warn_reg, warn_next;
    logic [31:0]   prdata_reg, prdata_next;
    logic          slverr_reg, slverr_next;

    logic          bit_q, hist_q;
    logic          bit_we, hist_we, bit_wd, hist_wd;
    logic [AW-1:0] wr_addr;
    logic          inhibit, multi_clear, exec;
    logic [ilsc_pkg::CNT_W-1:0] begin_count;
    logic          il_begin, il_clear, il_restart;
    logic          apb_setup, apb_wr, addr_ok;

    assign exec       = (state_reg == ilsc_pkg::ST_EXEC);
    assign STEP_READY = (state_reg == ilsc_pkg::ST_IDLE);
    assign il_begin   = exec && (op_reg == ilsc_pkg::OP_IL_BEGIN);
    assign il_clear   = exec && (op_reg == ilsc_pkg::OP_IL_CLEAR);
    assign il_restart = exec && (op_reg == ilsc_pkg::OP_SCAN_START);

    ////////////////////////////////////////////////////////////////////////
    // Storage and interlock tracking
    ilsc_bitmem #(.AW(AW), .DEPTH(1 << AW)) u_bits (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .we    (bit_we),
        .waddr (wr_addr),
        .wdata (bit_wd),
        .raddr (STEP_ADDR),
        .rdata (bit_q)
    );

    ilsc_bitmem #(.AW(AW), .DEPTH(1 << AW)) u_hist (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .we    (hist_we),
        .waddr (wr_addr),
        .wdata (hist_wd),
        .raddr (STEP_ADDR),
        .rdata (hist_q)
    );

    ilsc_ilock #(.CW(ilsc_pkg::CNT_W)) u_ilock (
        .clk         (CLK_SYS),
        .rst         (RESET),
        .begin_stb   (il_begin),
        .clear_stb   (il_clear),
        .restart_stb (il_restart),
        .cond        (cond_reg),
        .inhibit     (inhibit),
        .begin_count (begin_count),
        .multi_clear (multi_clear)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and step evaluation
    always_comb begin
        state_next    = state_reg;
        clr_addr_next = clr_addr_reg;
        op_next       = op_reg;
        addr_next     = addr_reg;
        cond_next     = cond_reg;
        set_next      = set_reg;
        rst_in_next   = rst_in_reg;
        rv_next       = 1'b0;
        ra_next       = ra_reg;
        rw_next       = 1'b0;
        rb_next       = rb_reg;
        tr_next       = 1'b0;
        ch_next       = 1'b0;
        ee_next       = 1'b0;
        bit_we        = 1'b0;
        hist_we       = 1'b0;
        bit_wd        = 1'b0;
        hist_wd       = 1'b0;
        wr_addr       = addr_reg;
        case (state_reg)
            ilsc_pkg::ST_CLEAR: begin
                // Only volatile areas are wiped; retained ones keep data
                bit_we  = 1'b1;
                hist_we = 1'b1;
                wr_addr = clr_addr_reg;
                clr_addr_next = clr_addr_reg + {{(AW-1){1'b0}}, 1'b1};
                if (clr_addr_reg == CLR_LAST) begin
                    state_next = ilsc_pkg::ST_IDLE;
                end
            end
            ilsc_pkg::ST_IDLE: begin
                if (STEP_VALID) begin
                    op_next     = STEP_OP;
                    addr_next   = STEP_ADDR;
                    cond_next   = STEP_COND;
                    set_next    = STEP_SET;
                    rst_in_next = STEP_RESET;
                    state_next  = ilsc_pkg::ST_EXEC;
                end
            end
            ilsc_pkg::ST_EXEC: begin
                state_next = ilsc_pkg::ST_IDLE;
                rv_next    = 1'b1;
                ra_next    = addr_reg;
                rb_next    = bit_q;
                // No flag outputs exist; these steps leave flags alone
                case (op_reg)
                    ilsc_pkg::OP_KEEP: begin
                        if (!inhibit) begin
                            if (rst_in_reg) begin
                                rb_next = 1'b0;
                            end else if (set_reg) begin
                                rb_next = 1'b1;
                            end
                            rw_next = 1'b1;
                        end
                    end
                    ilsc_pkg::OP_RISE, ilsc_pkg::OP_FALL: begin
                        // History frozen while inhibited
                        if (!inhibit) begin
                            hist_we = 1'b1;
                            hist_wd = cond_reg;
                            rw_next = 1'b1;
                            if (op_reg == ilsc_pkg::OP_RISE) begin
                                rb_next = cond_reg & ~hist_q;
                            end else begin
                                rb_next = ~cond_reg & hist_q;
                            end
                        end
                    end
                    ilsc_pkg::OP_OUT, ilsc_pkg::OP_OUT_NOT: begin
                        rw_next = 1'b1;
                        if (inhibit) begin
                            rb_next = 1'b0;
                        end else begin
                            rb_next = cond_reg ^
                                (op_reg == ilsc_pkg::OP_OUT_NOT);
                        end
                    end
                    ilsc_pkg::OP_TIMER: begin
                        tr_next = inhibit;
                        ee_next = ~inhibit;
                    end
                    ilsc_pkg::OP_COUNTER: begin
                        ch_next = inhibit;
                        ee_next = ~inhibit;
                    end
                    ilsc_pkg::OP_OTHER: begin
                        ee_next = ~inhibit;
                    end
                    default: begin
                        // Begin, clear and scan start only move the tracker.
                        // A stray clear just reopens an open section.
                    end
                endcase
                bit_we = rw_next;
                bit_wd = rb_next;
            end
            default: begin
                state_next = ilsc_pkg::ST_CLEAR;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data staged in the setup cycle
    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr    = PSEL && PENABLE && PWRITE;
    assign addr_ok   = (PADDR == ilsc_pkg::REG_CTRL) ||
                       (PADDR == ilsc_pkg::REG_STATUS);

    always_comb begin
        ctrl_next   = ctrl_reg;
        warn_next   = warn_reg;
        prdata_next = prdata_reg;
        slverr_next = slverr_reg;
        if (apb_setup) begin
            slverr_next = !addr_ok;
            prdata_next = 32'h00000000;
            if (PADDR == ilsc_pkg::REG_CTRL) begin
                prdata_next = ctrl_reg;
            end else if (PADDR == ilsc_pkg::REG_STATUS) begin
                prdata_next[ilsc_pkg::ST_INHIBIT] = inhibit;
                prdata_next[ilsc_pkg::ST_WARN]    = warn_reg;
                prdata_next[ilsc_pkg::ST_BUSY]    =
                    (state_reg == ilsc_pkg::ST_CLEAR);
                prdata_next[ilsc_pkg::ST_CNT_LSB +: ilsc_pkg::CNT_W] =
                    begin_count;
            end
        end
        if (apb_wr && PADDR == ilsc_pkg::REG_CTRL) begin
            ctrl_next = {31'h00000000, PWDATA[ilsc_pkg::CTRL_WARN_EN]};
        end
        if (apb_wr && PADDR == ilsc_pkg::REG_STATUS &&
            PWDATA[ilsc_pkg::ST_WARN]) begin
            warn_next = 1'b0;
        end
        // A new warning beats a clear in the same cycle
        if (multi_clear && ctrl_reg[ilsc_pkg::CTRL_WARN_EN]) begin
            warn_next = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state_reg    <= ilsc_pkg::ST_CLEAR;
            clr_addr_reg <= '0;
            op_reg       <= ilsc_pkg::OP_OTHER;
            addr_reg     <= '0;
            cond_reg     <= 1'b0;
            set_reg      <= 1'b0;
            rst_in_reg   <= 1'b0;
            rv_reg       <= 1'b0;
            ra_reg       <= '0;
            rw_reg       <= 1'b0;
            rb_reg       <= 1'b0;
            tr_reg       <= 1'b0;
            ch_reg       <= 1'b0;
            ee_reg       <= 1'b0;
            ctrl_reg     <= ilsc_pkg::CTRL_RESET;
            warn_reg     <= 1'b0;
            prdata_reg   <= 32'h00000000;
            slverr_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            clr_addr_reg <= clr_addr_next;
            op_reg       <= op_next;
            addr_reg     <= addr_next;
            cond_reg     <= cond_next;
            set_reg      <= set_next;
            rst_in_reg   <= rst_in_next;
            rv_reg       <= rv_next;
            ra_reg       <= ra_next;
            rw_reg       <= rw_next;
            rb_reg       <= rb_next;
            tr_reg       <= tr_next;
            ch_reg       <= ch_next;
            ee_reg       <= ee_next;
            ctrl_reg     <= ctrl_next;
            warn_reg     <= warn_next;
            prdata_reg   <= prdata_next;
            slverr_reg   <= slverr_next;
        end
    end

    assign PRDATA       = prdata_reg;
    assign PREADY       = 1'b1;
    assign PSLVERR      = slverr_reg && PSEL && PENABLE;
    assign RESULT_VALID = rv_reg;
    assign RESULT_ADDR  = ra_reg;
    assign RESULT_WRITE = rw_reg;
    assign RESULT_BIT   = rb_reg;
    assign TIMER_RESET  = tr_reg;
    assign COUNTER_HOLD = ch_reg;
    assign EXEC_ENABLE  = ee_reg;
    assign ILOCK_WARN   = warn_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_keep(logic s, logic r);
        exec && op_reg == ilsc_pkg::OP_KEEP && !inhibit &&
        set_reg == s && rst_in_reg == r;
    endsequence

    property p_keep_set;
        @(posedge CLK_SYS) disable iff (RESET)
        s_keep(1'b1, 1'b0) |=> RESULT_WRITE && RESULT_BIT;
    endproperty
    a_keep_set: assert property (p_keep_set)
        else $error("latch set did not drive bit on");

    property p_keep_reset;
        @(posedge CLK_SYS) disable iff (RESET)
        s_keep(1'b0, 1'b1) |=> RESULT_WRITE && !RESULT_BIT;
    endproperty
    a_keep_reset: assert property (p_keep_reset)
        else $error("latch reset did not drive bit off");

    property p_keep_prio;
        @(posedge CLK_SYS) disable iff (RESET)
        s_keep(1'b1, 1'b1) |=> !RESULT_BIT;
    endproperty
    a_keep_prio: assert property (p_keep_prio)
        else $error("latch reset lost to set");

    property p_keep_hold;
        @(posedge CLK_SYS) disable iff (RESET)
        exec && op_reg == ilsc_pkg::OP_KEEP && inhibit
            |-> !bit_we ##1 RESULT_VALID && !RESULT_WRITE;
    endproperty
    a_keep_hold: assert property (p_keep_hold)
        else $error("latch bit changed inside inhibited section");

    property p_out_off;
        @(posedge CLK_SYS) disable iff (RESET)
        exec && inhibit && (op_reg == ilsc_pkg::OP_OUT ||
            op_reg == ilsc_pkg::OP_OUT_NOT) |=> RESULT_WRITE && !RESULT_BIT;
    endproperty
    a_out_off: assert property (p_out_off)
        else $error("output coil not forced off");

    property p_no_record;
        @(posedge CLK_SYS) disable iff (RESET)
        exec && inhibit && (op_reg == ilsc_pkg::OP_RISE ||
            op_reg == ilsc_pkg::OP_FALL) |-> !hist_we;
    endproperty
    a_no_record: assert property (p_no_record)
        else $error("pulse history written while inhibited");

    property p_rise;
        @(posedge CLK_SYS) disable iff (RESET)
        exec && !inhibit && op_reg == ilsc_pkg::OP_RISE
            |=> RESULT_BIT == ($past(cond_reg) && !$past(hist_q));
    endproperty
    a_rise: assert property (p_rise)
        else $error("rising pulse value wrong");

    property p_fall;
        @(posedge CLK_SYS) disable iff (RESET)
        exec && !inhibit && op_reg == ilsc_pkg::OP_FALL
            |=> RESULT_BIT == (!$past(cond_reg) && $past(hist_q));
    endproperty
    a_fall: assert property (p_fall)
        else $error("falling pulse value wrong");

    property p_retain;
        @(posedge CLK_SYS) disable iff (RESET)
        bit_we && state_reg == ilsc_pkg::ST_CLEAR |-> wr_addr <= CLR_LAST;
    endproperty
    a_retain: assert property (p_retain)
        else $error("retained area wiped after reset");

    property p_warn;
        @(posedge CLK_SYS) disable iff (RESET)
        multi_clear && ctrl_reg[ilsc_pkg::CTRL_WARN_EN] |=> ILOCK_WARN;
    endproperty
    a_warn: assert property (p_warn)
        else $error("multi-begin warning missed");
endmodule : ilsc_scan
`default_nettype wire

// ==== ilsc_pkg.sv ====
// Constants and types shared by the latch and interlock scan block.
// Assumes a 32-bit APB register bus and one program step per request.
package ilsc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Program step operation codes
    localparam logic [3:0] OP_SCAN_START  = 4'h0;
    localparam logic [3:0] OP_KEEP        = 4'h1;
    localparam logic [3:0] OP_RISE        = 4'h2;
    localparam logic [3:0] OP_FALL        = 4'h3;
    localparam logic [3:0] OP_OUT         = 4'h4;
    localparam logic [3:0] OP_OUT_NOT     = 4'h5;
    localparam logic [3:0] OP_TIMER       = 4'h6;
    localparam logic [3:0] OP_COUNTER     = 4'h7;
    localparam logic [3:0] OP_OTHER       = 4'h8;
    localparam logic [3:0] OP_IL_BEGIN    = 4'h9;
    localparam logic [3:0] OP_IL_CLEAR    = 4'ha;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses) and fields
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam int          CTRL_WARN_EN  = 0;
    localparam logic [31:0] CTRL_RESET    = 32'h00000001;
    localparam int          ST_INHIBIT    = 0;
    localparam int          ST_WARN       = 1;
    localparam int          ST_BUSY       = 2;
    localparam int          ST_CNT_LSB    = 8;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int          ADDR_W        = 10;
    localparam int          RETAIN_BASE   = 768;
    localparam int          CNT_W         = 8;

    typedef enum logic [1:0] {
        ST_CLEAR = 2'b00,
        ST_IDLE  = 2'b01,
        ST_EXEC  = 2'b10
    } ilsc_state_t;

endpackage : ilsc_pkg

// ==== ilsc_bitmem.sv ====
// One-bit-wide memory for designated bits or pulse history.
// No reset on the array so retained areas survive; read data registered.
`timescale 1ns/10ps
`default_nettype none
module ilsc_bitmem #(
    parameter int AW    = ilsc_pkg::ADDR_W,
    parameter int DEPTH = 1 << ilsc_pkg::ADDR_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic          wdata,
    input  wire logic [AW-1:0] raddr,
    output logic               rdata
);
    logic [DEPTH-1:0] mem;
    logic             rdata_next;

    always_comb begin
        rdata_next = mem[raddr];
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 1'b0;
        end else begin
            rdata <= rdata_next;
        end
    end
endmodule : ilsc_bitmem
`default_nettype wire

// ==== ilsc_ilock.sv ====
// Interlock section tracker: running AND of section conditions.
// Assumes strobes are one-cycle pulses from the step sequencer.
`timescale 1ns/10ps
`default_nettype none
module ilsc_ilock #(
    parameter int CW = ilsc_pkg::CNT_W
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          begin_stb,
    input  wire logic          clear_stb,
    input  wire logic          restart_stb,
    input  wire logic          cond,
    output logic               inhibit,
    output logic [CW-1:0]      begin_count,
    output logic               multi_clear
);
    logic          open_reg;
    logic          open_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    always_comb begin
        open_next = open_reg;
        cnt_next  = cnt_reg;
        if (restart_stb || clear_stb) begin
            open_next = 1'b1;
            cnt_next  = '0;
        end else if (begin_stb) begin
            // Stacked begins narrow the same section
            open_next = open_reg & cond;
            if (cnt_reg != {CW{1'b1}}) begin
                cnt_next = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            open_reg <= 1'b1;
            cnt_reg  <= '0;
        end else begin
            open_reg <= open_next;
            cnt_reg  <= cnt_next;
        end
    end

    assign inhibit     = ~open_reg;
    assign begin_count = cnt_reg;
    // Only a warning; the section still clears normally
    assign multi_clear = clear_stb && (cnt_reg > {{(CW-1){1'b0}}, 1'b1});

    property p_clear_opens;
        @(posedge clk) disable iff (rst)
        clear_stb |=> !inhibit && (begin_count == '0);
    endproperty
    a_clear_opens: assert property (p_clear_opens)
        else $error("interlock not cancelled by clear");

    property p_stack;
        @(posedge clk) disable iff (rst)
        begin_stb && !clear_stb && !restart_stb && !cond |=> inhibit;
    endproperty
    a_stack: assert property (p_stack)
        else $error("off begin did not inhibit section");
endmodule : ilsc_ilock
`default_nettype wire

// ==== ilsc_prog_model.sv ====
// Ladder program model: hands one program step at a time to the block.
// Assumes issue() is called just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module ilsc_prog_model (
    input  wire logic clk,
    input  wire logic ready,
    output logic      valid,
    output logic [3:0] op,
    output logic [3:0] addr,
    output logic [2:0] csr
);
    initial begin
        {valid, op, addr, csr} = '0;
    end
    // Steps follow program order: clears only after begins
    // Latch reset inputs are plain, never an inverted AC input
    task automatic issue(input logic [3:0] o, a, input logic [2:0] c);
        int n = 0;
        {op, addr, csr} <= {o, a, c};
        valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 2000);
        valid <= 1'b0;
        // Released addr and csr lines flip so stale values cannot pass for live ones
        {addr, csr} <= ~{a, c};
    endtask : issue
endmodule : ilsc_prog_model
`default_nettype wire

// ==== ilsc_scan_tb_top.sv ====
// Bench for the latch and interlock scan block.
// Assumes a short clear span (RETAIN_BASE 4) and a 4-bit bit address.
`timescale 1ns/10ps
`default_nettype none
module ilsc_scan_tb_top;
    logic        clk, rst, psel, pen, pwr, prdy, perr, sv, srdy;
    logic        rbit, trst, chold, exen, rvld, rwr, warn, wseen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  sop, sadr, radr;
    logic [2:0]  csr;
    int          err_total, check_count;
    ilsc_scan #(.AW(4), .RETAIN_BASE(4)) DUT (
        .CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(prdy), .PSLVERR(perr), .STEP_VALID(sv), .STEP_READY(srdy),
        .STEP_OP(sop), .STEP_ADDR(sadr), .STEP_COND(csr[2]),
        .STEP_SET(csr[1]), .STEP_RESET(csr[0]), .RESULT_VALID(rvld),
        .RESULT_ADDR(radr), .RESULT_WRITE(rwr), .RESULT_BIT(rbit),
        .TIMER_RESET(trst), .COUNTER_HOLD(chold), .EXEC_ENABLE(exen),
        .ILOCK_WARN(warn));
    ilsc_prog_model prog (.clk(clk), .ready(srdy), .valid(sv), .op(sop),
        .addr(sadr), .csr(csr));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 100);
        if (prdy !== 1'b1) err_total++;
        q = prdata;
        q[31] = q[31] | perr;
        // One idle edge so the next call never reassigns psel at once
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask : apb
    // RESULT_VALID, RESULT_WRITE and the timer, counter and enable outputs are one-cycle pulses, so they are read at the edge
    // where the result is seen, before that edge's updates land
    task automatic st(input logic [3:0] o, a, input logic [2:0] c,
                      input logic [3:0] e);
        int n = 0;
        prog.issue(o, a, c);
        do begin
            @(posedge clk);
            n++;
        end while (rvld !== 1'b1 && n < 20);
        if (rvld !== 1'b1) err_total++;
        wseen = rwr;
        chk({24'h0, radr, rbit, trst, chold, exen}, {24'h0, a, e});
    endtask : st
    task automatic do_reset;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, ilsc_pkg::REG_STATUS, 32'h0);
        chk(q & 32'h4, 32'h4);
        apb(1'b0, ilsc_pkg::REG_CTRL, 32'h0);
        chk(q, ilsc_pkg::CTRL_RESET);
        apb(1'b1, ilsc_pkg::REG_CTRL, 32'h0);
        apb(1'b0, ilsc_pkg::REG_CTRL, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, ilsc_pkg::REG_CTRL, ilsc_pkg::CTRL_RESET);
        apb(1'b0, 12'h008, 32'h0);
        chk(q, 32'h80000000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_keep;
        st(ilsc_pkg::OP_SCAN_START, 4'h0, 3'b100, 4'h0);
        st(ilsc_pkg::OP_KEEP, 4'h9, 3'b010, 4'h8);
        st(ilsc_pkg::OP_KEEP, 4'h9, 3'b000, 4'h8);
        st(ilsc_pkg::OP_KEEP, 4'h9, 3'b001, 4'h0);
        st(ilsc_pkg::OP_KEEP, 4'h9, 3'b000, 4'h0);
        st(ilsc_pkg::OP_KEEP, 4'h9, 3'b011, 4'h0);
        st(ilsc_pkg::OP_KEEP, 4'h9, 3'b010, 4'h8);
        st(ilsc_pkg::OP_KEEP, 4'h1, 3'b010, 4'h8);
        chk({31'h0, wseen}, 32'h1);
        $display("test keep done");
    endtask : t_keep
    task automatic t_ilock;
        st(ilsc_pkg::OP_IL_BEGIN, 4'h0, 3'b100, 4'h0);
        st(ilsc_pkg::OP_IL_BEGIN, 4'h0, 3'b000, 4'h0);
        st(ilsc_pkg::OP_KEEP, 4'h1, 3'b001, 4'h8);
        chk({31'h0, wseen}, 32'h0);
        st(ilsc_pkg::OP_OUT, 4'h2, 3'b100, 4'h0);
        st(ilsc_pkg::OP_OUT_NOT, 4'h2, 3'b000, 4'h0);
        st(ilsc_pkg::OP_TIMER, 4'h3, 3'b100, 4'h4);
        st(ilsc_pkg::OP_COUNTER, 4'h3, 3'b100, 4'h2);
        st(ilsc_pkg::OP_OTHER, 4'h3, 3'b100, 4'h0);
        apb(1'b0, ilsc_pkg::REG_STATUS, 32'h0);
        chk(q & 32'hff01, 32'h0201);
        st(ilsc_pkg::OP_IL_CLEAR, 4'h0, 3'b100, 4'h0);
        st(ilsc_pkg::OP_OUT, 4'h2, 3'b100, 4'h8);
        st(ilsc_pkg::OP_TIMER, 4'h3, 3'b100, 4'h1);
        apb(1'b0, ilsc_pkg::REG_STATUS, 32'h0);
        chk(q & 32'h3, 32'h2);
        chk({31'h0, warn}, 32'h1);
        apb(1'b1, ilsc_pkg::REG_STATUS, 32'h2);
        apb(1'b0, ilsc_pkg::REG_STATUS, 32'h0);
        chk(q & 32'h2, 32'h0);
        chk({31'h0, warn}, 32'h0);
        $display("test interlock done");
    endtask : t_ilock
    task automatic t_pulse;
        st(ilsc_pkg::OP_RISE, 4'h2, 3'b000, 4'h0);
        st(ilsc_pkg::OP_RISE, 4'h2, 3'b100, 4'h8);
        st(ilsc_pkg::OP_RISE, 4'h2, 3'b100, 4'h0);
        st(ilsc_pkg::OP_FALL, 4'h3, 3'b100, 4'h0);
        st(ilsc_pkg::OP_FALL, 4'h3, 3'b000, 4'h8);
        st(ilsc_pkg::OP_FALL, 4'h3, 3'b000, 4'h0);
        st(ilsc_pkg::OP_IL_BEGIN, 4'h0, 3'b000, 4'h0);
        // Ends low inside the interlock: a recorded change would pulse
        st(ilsc_pkg::OP_RISE, 4'h2, 3'b100, 4'h0);
        st(ilsc_pkg::OP_RISE, 4'h2, 3'b000, 4'h0);
        st(ilsc_pkg::OP_IL_CLEAR, 4'h0, 3'b100, 4'h0);
        st(ilsc_pkg::OP_RISE, 4'h2, 3'b100, 4'h0);
        $display("test pulse done");
    endtask : t_pulse
    task automatic t_retain;
        do_reset();
        st(ilsc_pkg::OP_KEEP, 4'h9, 3'b000, 4'h8);
        st(ilsc_pkg::OP_KEEP, 4'h1, 3'b000, 4'h0);
        $display("test retain done");
    endtask : t_retain
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst, psel, pen, pwr, paddr, pwdata} = '0;
        {err_total, check_count} = '0;
        @(posedge clk);
        do_reset();
        t_regs();
        t_keep();
        t_ilock();
        t_pulse();
        t_retain();
        tally_and_finish();
    end
    // About 140 cycles are needed; the margin covers slow answers
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule : ilsc_scan_tb_top
`default_nettype wire
